//--- core/lebt_pkg.sv
// constants, types and decode functions of the laser enable and bias target register bank
// How it works
// - laser enable and bias writes take effect only at transmit-off state or later.
// - register writes never drive any module state machine signal.
// - module state changes never alter the laser enable setting.
// - laser enable resets to 0 and holds until the host writes it.
// - bit 15 set turns laser output power on.
// - bit 15 clear turns laser power off, laser controller and cooler stay running.
// - 3-bit bias codes 0 to 5 decode to first/second minimum, maximum or quadrature; codes 6 and 7 are reserved.
// - first and second count in the order found sweeping bias upward.
// - x in-phase target sits at bits 15..13, reset 000.
// - x quadrature at bits 12..10, y in-phase at 9..7, reset 000.
// - y quadrature at bits 6..4; bits 3..0 reserved, reset zero.
// - a written power change reaches its effect well inside 100 ms.
package lebt_pkg;

  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned SETTLE_TIME_MS = 100;
  // longest time, so the division rounds down
  localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned SETTLE_CNT_W = 25;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [15:0] ENABLE_REG_INDEX = 16'hbb32;
  localparam logic [15:0] BIAS_REG_INDEX = 16'hbb33;
  localparam logic [31:0] ENABLE_REG_ADDR = {14'h0000, ENABLE_REG_INDEX, 2'h0};
  localparam logic [31:0] BIAS_REG_ADDR = {14'h0000, BIAS_REG_INDEX, 2'h0};

  localparam int unsigned LASER_EN_BIT = 15;
  localparam logic LASER_EN_RESET = 1'b0;
  localparam logic [15:0] ENABLE_RW_MASK = 16'h8000;
  localparam logic [15:0] BIAS_RW_MASK = 16'hfff0;

  localparam int unsigned NUM_ARMS = 4;
  localparam int unsigned FIELD_W = 3;
  // arm 0 x in-phase, 1 x quadrature, 2 y in-phase, 3 y quadrature
  localparam int unsigned ARM_LSB [NUM_ARMS] = '{13, 10, 7, 4};
  localparam logic [2:0] BIAS_FIELD_RESET = 3'h0;

  localparam logic [2:0] CODE_MIN_FIRST = 3'h0;
  localparam logic [2:0] CODE_MIN_SECOND = 3'h1;
  localparam logic [2:0] CODE_MAX_FIRST = 3'h2;
  localparam logic [2:0] CODE_MAX_SECOND = 3'h3;
  localparam logic [2:0] CODE_QUAD_FIRST = 3'h4;
  localparam logic [2:0] CODE_QUAD_SECOND = 3'h5;

  localparam logic [31:0] HRDATA_IDLE = 32'h0000_0000;

  typedef enum logic [1:0] {
    LEBT_SEL_NONE,
    LEBT_SEL_ENABLE,
    LEBT_SEL_BIAS
  } lebt_sel_type;

  typedef enum logic [1:0] {
    LEBT_KIND_MIN,
    LEBT_KIND_MAX,
    LEBT_KIND_QUAD,
    LEBT_KIND_NONE
  } lebt_kind_type;

  function automatic lebt_sel_type lebt_reg_sel(input logic [31:0] addr);
    lebt_sel_type sel;
    sel = LEBT_SEL_NONE;
    if (addr == ENABLE_REG_ADDR) begin
      sel = LEBT_SEL_ENABLE;
    end else if (addr == BIAS_REG_ADDR) begin
      sel = LEBT_SEL_BIAS;
    end
    return sel;
  endfunction : lebt_reg_sel

  function automatic lebt_kind_type lebt_code_kind(input logic [2:0] code);
    lebt_kind_type kind;
    case (code)
      CODE_MIN_FIRST, CODE_MIN_SECOND: kind = LEBT_KIND_MIN;
      CODE_MAX_FIRST, CODE_MAX_SECOND: kind = LEBT_KIND_MAX;
      CODE_QUAD_FIRST, CODE_QUAD_SECOND: kind = LEBT_KIND_QUAD;
      default: kind = LEBT_KIND_NONE;
    endcase
    return kind;
  endfunction : lebt_code_kind

endpackage : lebt_pkg

//--- core/lebt_regbus_if.sv
// internal register access carrier between the bus slave and the register bank
interface lebt_regbus_if;
  import lebt_pkg::*;
  logic wr_en;
  lebt_sel_type wr_sel;
  logic [15:0] wr_data;
  logic [15:0] enable_view;
  logic [15:0] bias_view;
  modport slave (output wr_en, output wr_sel, output wr_data,
                 input enable_view, input bias_view);
  modport bank (input wr_en, input wr_sel, input wr_data,
                output enable_view, output bias_view);
endinterface : lebt_regbus_if

//--- core/lebt_ahb_slave.sv
// AHB-Lite slave front end: zero wait states, always OKAY
module lebt_ahb_slave
  import lebt_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  lebt_regbus_if.slave bus
);

  logic dp_wr_reg, dp_wr_next;
  logic dp_rd_reg, dp_rd_next;
  lebt_sel_type dp_sel_reg, dp_sel_next;
  logic addr_phase;

  // only whole-word transfers are expected; hsize is not checked
  assign addr_phase = hsel_in & htrans_in[1] & hready_in;

  always_comb begin
    dp_wr_next = addr_phase & hwrite_in;
    dp_rd_next = addr_phase & ~hwrite_in;
    dp_sel_next = addr_phase ? lebt_reg_sel(haddr_in) : LEBT_SEL_NONE;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_sel_reg <= LEBT_SEL_NONE;
    end else begin
      dp_wr_reg <= dp_wr_next;
      dp_rd_reg <= dp_rd_next;
      dp_sel_reg <= dp_sel_next;
    end
  end

  assign bus.wr_en = dp_wr_reg;
  assign bus.wr_sel = dp_sel_reg;
  assign bus.wr_data = hwdata_in[15:0];

  // unmapped reads return zero
  always_comb begin
    hrdata_out = HRDATA_IDLE;
    if (dp_rd_reg) begin
      case (dp_sel_reg)
        LEBT_SEL_ENABLE: hrdata_out = {16'h0000, bus.enable_view};
        LEBT_SEL_BIAS: hrdata_out = {16'h0000, bus.bias_view};
        default: hrdata_out = HRDATA_IDLE;
      endcase
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

endmodule : lebt_ahb_slave

//--- core/lebt_regs.sv
// laser output enable and inner bias target register bank with AHB-Lite access
//
// The AHB-Lite slave port was left to the implementer.
module lebt_regs
  import lebt_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic tx_off_or_later_in,
  output logic laser_power_on_out,
  output logic laser_ctrl_run_out,
  output logic thermo_cooler_run_out,
  output logic settle_pending_out,
  output logic [NUM_ARMS-1:0][2:0] arm_target_code_out,
  output logic [NUM_ARMS-1:0][1:0] arm_target_kind_out,
  output logic [NUM_ARMS-1:0] arm_target_second_out,
  output logic [NUM_ARMS-1:0] arm_target_valid_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus front end

  lebt_regbus_if regbus ();

  lebt_ahb_slave u_slave (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .bus(regbus.slave)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic laser_en_reg, laser_en_next;
  logic [15:0] bias_reg, bias_next;
  logic wr_enable_ok;
  logic wr_bias_ok;

  // writes before transmit-off are dropped silently; the bus still answers OKAY
  assign wr_enable_ok = regbus.wr_en & (regbus.wr_sel == LEBT_SEL_ENABLE) &
                        tx_off_or_later_in;
  assign wr_bias_ok = regbus.wr_en & (regbus.wr_sel == LEBT_SEL_BIAS) &
                      tx_off_or_later_in;

  always_comb begin
    laser_en_next = laser_en_reg;
    bias_next = bias_reg;
    // the module state input only gates writes, it never touches stored values
    if (wr_enable_ok) begin
      laser_en_next = regbus.wr_data[LASER_EN_BIT];
    end
    if (wr_bias_ok) begin
      bias_next = regbus.wr_data & BIAS_RW_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      laser_en_reg <= LASER_EN_RESET;
      bias_reg <= {BIAS_FIELD_RESET, BIAS_FIELD_RESET, BIAS_FIELD_RESET,
                   BIAS_FIELD_RESET, 4'h0};
    end else begin
      laser_en_reg <= laser_en_next;
      bias_reg <= bias_next;
    end
  end

  // reserved bits read zero
  assign regbus.enable_view = {laser_en_reg, 15'h0000} & ENABLE_RW_MASK;
  assign regbus.bias_view = bias_reg & BIAS_RW_MASK;

  ////////////////////////////////////////////////////////////////////////////////
  // laser power and settle window

  logic power_on_reg, power_on_next;
  logic [SETTLE_CNT_W-1:0] settle_cnt_reg, settle_cnt_next;

  always_comb begin
    power_on_next = laser_en_reg;
    settle_cnt_next = settle_cnt_reg;
    // power follows in two cycles; the window only tells firmware when optics should be settled
    if (wr_enable_ok && (regbus.wr_data[LASER_EN_BIT] != laser_en_reg)) begin
      settle_cnt_next = SETTLE_CNT_W'(SETTLE_CYCLES_P);
    end else if (settle_cnt_reg != '0) begin
      settle_cnt_next = settle_cnt_reg - SETTLE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      power_on_reg <= 1'b0;
      settle_cnt_reg <= '0;
    end else begin
      power_on_reg <= power_on_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  assign laser_power_on_out = power_on_reg;
  // controller and cooler are not gated by the enable, so warm-up is kept while dark
  assign laser_ctrl_run_out = 1'b1;
  assign thermo_cooler_run_out = 1'b1;
  assign settle_pending_out = (settle_cnt_reg != '0);

  ////////////////////////////////////////////////////////////////////////////////
  // bias target decode, one arm per field

  logic [NUM_ARMS-1:0][2:0] code_reg, code_next;
  logic [NUM_ARMS-1:0][1:0] kind_reg, kind_next;
  logic [NUM_ARMS-1:0] second_reg, second_next;
  logic [NUM_ARMS-1:0] valid_reg, valid_next;

  generate
    for (genvar a = 0; a < NUM_ARMS; a++) begin : g_arm
      always_comb begin
        code_next[a] = bias_reg[ARM_LSB[a] +: FIELD_W];
        kind_next[a] = lebt_code_kind(code_next[a]);
        // odd codes are the second point met on an upward sweep
        second_next[a] = code_next[a][0];
        // reserved codes are stored but flagged so the controller holds its lock
        valid_next[a] = (lebt_code_kind(code_next[a]) != LEBT_KIND_NONE);
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      code_reg <= '0;
      kind_reg <= '0;
      second_reg <= '0;
      valid_reg <= '1;
    end else begin
      code_reg <= code_next;
      kind_reg <= kind_next;
      second_reg <= second_next;
      valid_reg <= valid_next;
    end
  end

  assign arm_target_code_out = code_reg;
  assign arm_target_kind_out = kind_reg;
  assign arm_target_second_out = second_reg;
  assign arm_target_valid_out = valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // read path observer for the checks

  // rebuilt from the bus pins so the read checks do not lean on the slave's own decode
  logic obs_rd_reg, obs_rd_next;
  logic [31:0] obs_addr_reg, obs_addr_next;
  logic enable_flip;

  always_comb begin
    obs_rd_next = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
    obs_addr_next = haddr_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      obs_rd_reg <= 1'b0;
      obs_addr_reg <= 32'h0000_0000;
    end else begin
      obs_rd_reg <= obs_rd_next;
      obs_addr_reg <= obs_addr_next;
    end
  end

  assign enable_flip = wr_enable_ok & (regbus.wr_data[LASER_EN_BIT] != laser_en_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_enable_write(logic v);
    regbus.wr_en && regbus.wr_sel == LEBT_SEL_ENABLE && regbus.wr_data[LASER_EN_BIT] == v;
  endsequence

  sequence s_bias_write;
    regbus.wr_en && regbus.wr_sel == LEBT_SEL_BIAS;
  endsequence

  sequence s_enable_any;
    regbus.wr_en && regbus.wr_sel == LEBT_SEL_ENABLE;
  endsequence

  sequence s_read_of(logic [31:0] addr);
    obs_rd_reg && obs_addr_reg == addr;
  endsequence

  gated_write_a: assert property (
    s_enable_any ##0 !tx_off_or_later_in |=> $stable(laser_en_reg))
    else $error("enable changed by a write before transmit-off");

  bias_gated_a: assert property (
    s_bias_write ##0 !tx_off_or_later_in |=> $stable(bias_reg))
    else $error("bias targets changed by a write before transmit-off");

  enable_on_a: assert property (
    s_enable_write(1'b1) ##0 tx_off_or_later_in |=> laser_en_reg ##1 laser_power_on_out)
    else $error("laser power not on two cycles after enable write");

  enable_off_a: assert property (
    s_enable_write(1'b0) ##0 tx_off_or_later_in |=> !laser_en_reg ##1
    (!laser_power_on_out && laser_ctrl_run_out && thermo_cooler_run_out))
    else $error("laser power not off or controller stopped after disable");

  state_decoupled_a: assert property (
    !(regbus.wr_en && regbus.wr_sel == LEBT_SEL_ENABLE) && $changed(tx_off_or_later_in)
    |-> laser_en_next == laser_en_reg)
    else $error("enable setting moved with the module state");

  hold_until_write_a: assert property (
    $changed(laser_en_reg) |-> $past(wr_enable_ok))
    else $error("enable changed without a host write");

  reserved_zero_a: assert property (
    regbus.enable_view[14:0] == 15'h0000 && regbus.bias_view[3:0] == 4'h0 &&
    bias_reg[3:0] == 4'h0)
    else $error("reserved bits not zero");

  field_map_a: assert property (
    s_bias_write ##0 tx_off_or_later_in |=>
    bias_reg[15:13] == $past(regbus.wr_data[15:13]) ##1
    arm_target_code_out[0] == $past(regbus.wr_data[15:13], 2))
    else $error("x in-phase target not at bits 15 to 13");

  arm_fields_a: assert property (
    arm_target_code_out[1] == $past(bias_reg[12:10]) &&
    arm_target_code_out[2] == $past(bias_reg[9:7]) &&
    arm_target_code_out[3] == $past(bias_reg[6:4]))
    else $error("arm target field placement wrong");

  decode_kind_a: assert property (
    arm_target_code_out[0] == CODE_QUAD_SECOND |->
    arm_target_kind_out[0] == LEBT_KIND_QUAD && arm_target_second_out[0] &&
    arm_target_valid_out[0])
    else $error("second quadrature code decoded wrongly");

  decode_reserved_a: assert property (
    arm_target_code_out[3][2:1] == 2'h3 |-> !arm_target_valid_out[3])
    else $error("reserved code marked valid");

  settle_window_a: assert property (
    wr_enable_ok && regbus.wr_data[LASER_EN_BIT] != laser_en_reg
    |=> settle_pending_out && settle_cnt_reg == SETTLE_CNT_W'(SETTLE_CYCLES_P))
    else $error("settle window not started on enable change");

  enable_hold_a: assert property (
    !wr_enable_ok |=> $stable(laser_en_reg))
    else $error("enable moved without an accepted write");

  bias_hold_a: assert property (
    !wr_bias_ok |=> $stable(bias_reg))
    else $error("bias targets moved without an accepted write");

  bias_store_a: assert property (
    s_bias_write ##0 tx_off_or_later_in |=>
    bias_reg[15:4] == $past(regbus.wr_data[15:4]) && bias_reg[3:0] == 4'h0)
    else $error("bias write not stored with reserved bits cleared");

  read_enable_a: assert property (
    s_read_of(ENABLE_REG_ADDR) |-> hrdata_out == {16'h0000, laser_en_reg, 15'h0000})
    else $error("enable read data wrong");

  read_bias_a: assert property (
    s_read_of(BIAS_REG_ADDR) |-> hrdata_out == {16'h0000, bias_reg[15:4], 4'h0})
    else $error("bias target read data wrong");

  read_other_a: assert property (
    !obs_rd_reg || (obs_addr_reg != ENABLE_REG_ADDR && obs_addr_reg != BIAS_REG_ADDR)
    |-> hrdata_out == HRDATA_IDLE)
    else $error("read data outside a register read not zero");

  bus_okay_a: assert property (
    hreadyout_out && !hresp_out)
    else $error("bus answer not ready and okay");

  power_follow_a: assert property (
    laser_power_on_out == $past(laser_en_reg))
    else $error("laser power does not follow the stored enable");

  settle_count_a: assert property (
    settle_cnt_reg != '0 && !enable_flip
    |=> settle_cnt_reg == $past(settle_cnt_reg) - SETTLE_CNT_W'(1))
    else $error("settle window not counting down");

  settle_quiet_a: assert property (
    settle_cnt_reg == '0 && !enable_flip |=> !settle_pending_out)
    else $error("settle window opened without an enable change");

  settle_bound_a: assert property (
    settle_cnt_reg <= SETTLE_CNT_W'(SETTLE_CYCLES_P))
    else $error("settle count above its window");

  reset_state_a: assert property (
    $past(sys_rst_in) |-> laser_en_reg == LASER_EN_RESET && !laser_power_on_out &&
    bias_reg == {{NUM_ARMS{BIAS_FIELD_RESET}}, 4'h0} && !settle_pending_out &&
    arm_target_valid_out == '1)
    else $error("state after reset wrong");

  // one set of decode checks per arm
  generate
    for (genvar a = 0; a < NUM_ARMS; a++) begin : g_arm_chk
      arm_min_a: assert property (
        arm_target_code_out[a][2:1] == 2'h0 |->
        arm_target_kind_out[a] == LEBT_KIND_MIN && arm_target_valid_out[a])
        else $error("minimum code decoded wrongly");

      arm_max_a: assert property (
        arm_target_code_out[a][2:1] == 2'h1 |->
        arm_target_kind_out[a] == LEBT_KIND_MAX && arm_target_valid_out[a])
        else $error("maximum code decoded wrongly");

      arm_quad_a: assert property (
        arm_target_code_out[a][2:1] == 2'h2 |->
        arm_target_kind_out[a] == LEBT_KIND_QUAD && arm_target_valid_out[a])
        else $error("quadrature code decoded wrongly");

      arm_order_a: assert property (
        arm_target_second_out[a] == arm_target_code_out[a][0])
        else $error("first or second point flag wrong");
    end
  endgenerate

endmodule : lebt_regs

//--- tb/lebt_host_model.sv
// host-side AHB-Lite master model issuing single word transfers
module lebt_host_model (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0000_0000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // call just after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    haddr_out <= addr;
    hwrite_out <= wr;
    // data lines in an address phase carry garbage, never the last value
    hwdata_out <= ~hwdata_out;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    haddr_out <= ~addr;
    hwdata_out <= wdata;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    rdata = hrdata_in;
  endtask : xfer
endmodule : lebt_host_model

//--- tb/tb_laser_enable_and_bias_target_regs.sv
// self-checking bench of the laser enable and bias target register bank
module tb_laser_enable_and_bias_target_regs
  import lebt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // short settle window keeps the run brief
  localparam int unsigned SETTLE_SIM = 16;
  logic clk_in, sys_rst_in, tx_off, hsel, hwrite, hready, hresp;
  logic laser_on, ctrl_run, cooler_run, settle;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat, wval, seed;
  logic [NUM_ARMS-1:0][2:0] code;
  logic [NUM_ARMS-1:0][1:0] kind;
  logic [NUM_ARMS-1:0] second, valid;
  logic [2:0] c [NUM_ARMS];
  logic en;
  int mismatches, n_checks;

  lebt_regs #(.SETTLE_CYCLES_P(SETTLE_SIM)) lebt_regs_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .tx_off_or_later_in(tx_off), .laser_power_on_out(laser_on), .laser_ctrl_run_out(ctrl_run),
    .thermo_cooler_run_out(cooler_run), .settle_pending_out(settle),
    .arm_target_code_out(code), .arm_target_kind_out(kind),
    .arm_target_second_out(second), .arm_target_valid_out(valid));

  lebt_host_model lebt_host_model_inst (.clk_in(clk_in), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [1:0] exp_kind(input logic [2:0] cd);
    if (cd < 3'h2) return 2'h0;
    if (cd < 3'h4) return 2'h1;
    if (cd < 3'h6) return 2'h2;
    return 2'h3;
  endfunction : exp_kind

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    sys_rst_in = 1'b1;
    tx_off = 1'b0;
    seed = 32'h0000_190a;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    chk(32'(laser_on), 32'h0000_0000);
    chk(32'({ctrl_run, cooler_run}), 32'h0000_0003);
    lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_0000);
    lebt_host_model_inst.xfer(1'b0, BIAS_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_0000);
    // write before transmit-off must be dropped
    lebt_host_model_inst.xfer(1'b1, ENABLE_REG_ADDR, 32'hffff_ffff, rdat);
    lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_0000);
    chk(32'(laser_on), 32'h0000_0000);
    tx_off <= 1'b1;
    lebt_host_model_inst.xfer(1'b1, ENABLE_REG_ADDR, 32'hffff_ffff, rdat);
    @(posedge clk_in);
    #1;
    chk(32'({laser_on, settle}), 32'h0000_0003);
    lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_8000);
    repeat (SETTLE_SIM + 2) @(posedge clk_in);
    #1;
    chk(32'(settle), 32'h0000_0000);
    // leaving the state must not touch the enable
    tx_off <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk(32'(laser_on), 32'h0000_0001);
    lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_8000);
    en = 1'b1;
    for (int i = 0; i < 10; i++) begin
      wval = xs();
      tx_off <= wval[0];
      if (wval[0]) en = wval[15];
      lebt_host_model_inst.xfer(1'b1, ENABLE_REG_ADDR, wval, rdat);
      lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
      chk(rdat, {16'h0000, en, 15'h0000});
      chk(32'({laser_on, ctrl_run, cooler_run}), 32'({en, 2'h3}));
    end
    tx_off <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      wval = xs();
      for (int a = 0; a < NUM_ARMS; a++) begin
        // host never writes the reserved codes
        c[a] = (i < 6) ? 3'(i) : 3'(xs() % 6);
      end
      wval[15:4] = {c[0], c[1], c[2], c[3]};
      lebt_host_model_inst.xfer(1'b1, BIAS_REG_ADDR, wval, rdat);
      lebt_host_model_inst.xfer(1'b0, BIAS_REG_ADDR, 32'h0000_0000, rdat);
      chk(rdat, {16'h0000, wval[15:4], 4'h0});
      for (int a = 0; a < NUM_ARMS; a++) begin
        chk(32'(code[a]), 32'(c[a]));
        chk(32'(kind[a]), 32'(exp_kind(c[a])));
        chk(32'({second[a], valid[a]}), 32'({c[a][0], 1'b1}));
      end
    end
    // unmapped place: write lost, read zero
    // no drive signal register lives here, so no control loop has to be off first
    lebt_host_model_inst.xfer(1'b1, BIAS_REG_ADDR + 32'h0000_0004, 32'hffff_ffff, rdat);
    lebt_host_model_inst.xfer(1'b0, BIAS_REG_ADDR + 32'h0000_0004, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_0000);
    lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, {16'h0000, en, 15'h0000});
    chk(32'({hready, hresp}), 32'h0000_0002);
    // second reset in mid-run must bring a set enable back to off
    lebt_host_model_inst.xfer(1'b1, ENABLE_REG_ADDR, 32'h0000_8000, rdat);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    lebt_host_model_inst.xfer(1'b0, ENABLE_REG_ADDR, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : tb_laser_enable_and_bias_target_regs
